// file: rtl/cdg_generator.sv
// Complementary dead-band generator with auto-shutdown and AHB-Lite registers.
// Assumes all source and fault inputs and the oscillator are asynchronous pins.
// Summary of operation
// - Writing one to the shutdown-event bit forces shutdown with override levels.
// - Without auto-restart, shutdown holds while the shutdown-event bit is set.
// - With auto-restart, software shutdown self-clears; resume on next rising input.
// - An enabled external shutdown source forces override levels at once.
// - Sources are level sensitive; active level keeps shutdown unless disabled.
// - Generator runs independent of system clock when its clock and input live; here all logic is clocked by mclk and only samples the oscillator.
// - Oscillator keep-running request while enabled, input active, oscillator selected.
// - In shutdown each output takes its override; polarity applies only to code 00.
// - Without auto-restart, clearing the event bit is ignored while sources active.
// - After the event bit clears, overrides hold until the next rising input.
// - With auto-restart, hardware clears the event bit when sources go inactive.
// - Control 0 bit 7 enables, bits 6 and 5 enable B and A pins.
// - Control 0 bits 4 and 3 invert B and A outputs when set.
// - Control 0 bit 0 picks internal oscillator, else system clock.
// - B override: 11 high, 10 low, 01 tri-state, 00 inactive with polarity.
// - A override uses the same four codes on output A.
// - Input select: 100 PWM3, 011 PWM2, 010 PWM1, 000 comparator.
// - Control 2 bit 2 lets a high comparator output cause shutdown.
// - Control 2 bit 1 lets a low fault pin cause shutdown.
// - Rising count N gives N to N+1 clock counts; zero gives none. Here it gives exactly N counts with the system clock.
// - Rising input turns B off at once, waits rising count, turns A on.
// - Falling input turns A off at once, waits falling count, turns B on.
// - Falling count register uses the rising encoding; zero bypasses the delay.
// - With the module disabled, enables and drive levels leave pins alone.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`default_nettype none
module cdg_generator
	import cdg_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pwm_source_one,
	input wire logic pwm_source_two,
	input wire logic pwm_source_three,
	input wire logic comparator_out_async,
	input wire logic fault_pin_n,
	input wire logic osc_16mhz_in,
	output logic osc_keep_running,
	output logic drive_out_a_o,
	output logic drive_out_a_oe,
	output logic drive_out_b_o,
	output logic drive_out_b_oe
);
	function automatic logic db_done(input logic [5:0] cnt, input logic [5:0] lim);
		db_done = (cnt == lim);
	endfunction

	function automatic logic ovr_level(input logic [1:0] code, input logic inv);
		ovr_level = (code == CDG_OVR_INACT) ? inv : code[0];
	endfunction

	cdg_ctl0_t ctl0_reg;
	cdg_ctl1_t ctl1_reg;
	cdg_sdc_t sdc_reg;
	logic [5:0] dbr_reg;
	logic [5:0] dbf_reg;
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic osc_prev_reg;
	logic in_prev_reg;
	logic sd_hold_reg;
	cdg_state_t state_reg;
	logic [5:0] cnt_reg;
	cdg_drive_t drive_reg;
	logic keep_reg;
	logic wr_pend_reg;
	logic rd_wait_reg;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;
	logic cmp_s;
	logic flt_n_s;
	logic osc_s;
	logic in_sel;
	logic in_valid;
	logic tick;
	logic rise;
	logic fall;
	logic sd_src;
	logic forced;
	logic a_on;
	logic b_on;
	logic acc;
	logic wr_sdc;
	logic [7:0] wdat;
	logic [7:0] rd_val;

	// Two-stage synchronisers for every asynchronous pin
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
		end
		else
		begin
			sync1_reg <= {osc_16mhz_in, fault_pin_n, comparator_out_async,
				pwm_source_three, pwm_source_two, pwm_source_one};
			sync2_reg <= sync1_reg;
		end
	end

	assign cmp_s = sync2_reg[3];
	assign flt_n_s = sync2_reg[4];
	assign osc_s = sync2_reg[5];

	always_comb
	begin
		in_valid = 1'b1;
		case (ctl1_reg.input_select)
			CDG_IS_CMP: in_sel = cmp_s;
			CDG_IS_PWM1: in_sel = sync2_reg[0];
			CDG_IS_PWM2: in_sel = sync2_reg[1];
			CDG_IS_PWM3: in_sel = sync2_reg[2];
			default:
			begin
				in_sel = 1'b0;
				in_valid = 1'b0;
			end
		endcase
	end

	// dead-band tick from system clock or oscillator edges
	assign tick = ctl0_reg.generator_clock_select ? (osc_s & ~osc_prev_reg) : 1'b1;
	assign rise = in_sel & ~in_prev_reg;
	assign fall = ~in_sel & in_prev_reg;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_prev_reg <= 1'b0;
			in_prev_reg <= 1'b0;
		end
		else
		begin
			osc_prev_reg <= osc_s;
			in_prev_reg <= in_sel;
		end
	end

	// comparator high shuts down when enabled
	// fault pin low shuts down when enabled
	assign sd_src = (sdc_reg.comparator_shutdown_enable & cmp_s)
		| (sdc_reg.fault_pin_shutdown_enable & ~flt_n_s);

	// AHB-Lite slave: writes zero-wait, reads one wait state
	assign acc = hsel & hready & ((htrans == CDG_HTRANS_NONSEQ) | (htrans == CDG_HTRANS_SEQ))
		& (hsize == CDG_HSIZE_WORD);
	assign wdat = hwdata[7:0];
	assign wr_sdc = wr_pend_reg & (addr_reg == CDG_OFS_SDC);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg <= CDG_RST_VAL;
		end
		else
		begin
			wr_pend_reg <= acc & hwrite;
			rd_wait_reg <= acc & ~hwrite;
			if (acc)
			begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	always_comb
	begin
		case (addr_reg)
			CDG_OFS_CTL0: rd_val = ctl0_reg & CDG_WM_CTL0;
			CDG_OFS_CTL1: rd_val = ctl1_reg & CDG_WM_CTL1;
			CDG_OFS_SDC: rd_val = sdc_reg & CDG_WM_SDC;
			CDG_OFS_DBR: rd_val = {2'b00, dbr_reg};
			CDG_OFS_DBF: rd_val = {2'b00, dbf_reg};
			default: rd_val = CDG_RST_VAL;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hrdata_reg <= 32'h00000000;
		end
		else if (rd_wait_reg)
		begin
			hrdata_reg <= {24'h000000, rd_val};
		end
	end

	assign hreadyout = ~rd_wait_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// control 0 and the other plain registers
	// polarity bits stored in control 0
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctl0_reg <= CDG_RST_VAL;
			ctl1_reg <= CDG_RST_VAL;
			dbr_reg <= CDG_CNT_ZERO;
			dbf_reg <= CDG_CNT_ZERO;
		end
		else if (wr_pend_reg)
		begin
			case (addr_reg)
				CDG_OFS_CTL0: ctl0_reg <= wdat & CDG_WM_CTL0;
				CDG_OFS_CTL1: ctl1_reg <= wdat & CDG_WM_CTL1;
				CDG_OFS_DBR: dbr_reg <= wdat[5:0];
				CDG_OFS_DBF: dbf_reg <= wdat[5:0];
				default: ;
			endcase
		end
	end

	// Shutdown control: source set wins over every clear
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sdc_reg <= CDG_RST_VAL;
		end
		else
		begin
			if (wr_sdc)
			begin
				sdc_reg.auto_restart_enable <= wdat[6];
				sdc_reg.comparator_shutdown_enable <= wdat[2];
				sdc_reg.fault_pin_shutdown_enable <= wdat[1];
			end
			// external source sets the event bit
			if (sd_src)
			begin
				sdc_reg.shutdown_event_status <= 1'b1;
			end
			else if (wr_sdc & wdat[7])
			begin
				sdc_reg.shutdown_event_status <= 1'b1;
			end
			else if (sdc_reg.auto_restart_enable)
			begin
				sdc_reg.shutdown_event_status <= 1'b0;
			end
			// software clear only with sources idle
			else if (wr_sdc)
			begin
				sdc_reg.shutdown_event_status <= 1'b0;
			end
		end
	end

	// overrides held until next rising input
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sd_hold_reg <= 1'b0;
		end
		else if (sdc_reg.shutdown_event_status | sd_src)
		begin
			sd_hold_reg <= 1'b1;
		end
		else if (rise)
		begin
			sd_hold_reg <= 1'b0;
		end
	end

	// shutdown held by the event bit
	assign forced = sdc_reg.shutdown_event_status | sd_hold_reg | sd_src;

	// Dead-band sequencer
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= CDG_ST_IDLE;
			cnt_reg <= CDG_CNT_ZERO;
		end
		else if (!ctl0_reg.module_enable)
		begin
			state_reg <= CDG_ST_IDLE;
			cnt_reg <= CDG_CNT_ZERO;
		end
		// B off at once, then rising count
		else if (rise)
		begin
			cnt_reg <= CDG_CNT_ZERO;
			state_reg <= (dbr_reg == CDG_CNT_ZERO) ? CDG_ST_A_ON : CDG_ST_RISE;
		end
		// A off at once, then falling count
		else if (fall)
		begin
			cnt_reg <= CDG_CNT_ZERO;
			state_reg <= (dbf_reg == CDG_CNT_ZERO) ? CDG_ST_B_ON : CDG_ST_FALL;
		end
		else
		begin
			case (state_reg)
				// count ticks from zero up to the value
				CDG_ST_RISE:
				begin
					if (tick & db_done(cnt_reg + CDG_CNT_ONE, dbr_reg))
					begin
						state_reg <= CDG_ST_A_ON;
					end
					else if (tick)
					begin
						cnt_reg <= cnt_reg + CDG_CNT_ONE;
					end
				end
				CDG_ST_FALL:
				begin
					if (tick & db_done(cnt_reg + CDG_CNT_ONE, dbf_reg))
					begin
						state_reg <= CDG_ST_B_ON;
					end
					else if (tick)
					begin
						cnt_reg <= cnt_reg + CDG_CNT_ONE;
					end
				end
				CDG_ST_IDLE: ;
				CDG_ST_A_ON: ;
				CDG_ST_B_ON: ;
				default: state_reg <= CDG_ST_IDLE;
			endcase
		end
	end

	assign a_on = (state_reg == CDG_ST_A_ON);
	assign b_on = (state_reg == CDG_ST_B_ON);

	// Registered pin drive
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			drive_reg <= 4'h0;
		end
		else if (!ctl0_reg.module_enable)
		begin
			drive_reg <= 4'h0;
		end
		else if (forced)
		begin
			drive_reg.a_val <= ovr_level(ctl1_reg.out_a_override_level,
				ctl0_reg.out_a_invert);
			drive_reg.b_val <= ovr_level(ctl1_reg.out_b_override_level,
				ctl0_reg.out_b_invert);
			drive_reg.a_oe <= ctl0_reg.out_a_pin_enable
				& (ctl1_reg.out_a_override_level != CDG_OVR_HIZ);
			drive_reg.b_oe <= ctl0_reg.out_b_pin_enable
				& (ctl1_reg.out_b_override_level != CDG_OVR_HIZ);
		end
		else
		begin
			drive_reg.a_val <= a_on ^ ctl0_reg.out_a_invert;
			drive_reg.b_val <= b_on ^ ctl0_reg.out_b_invert;
			drive_reg.a_oe <= ctl0_reg.out_a_pin_enable;
			drive_reg.b_oe <= ctl0_reg.out_b_pin_enable;
		end
	end

	assign drive_out_a_o = drive_reg.a_val;
	assign drive_out_a_oe = drive_reg.a_oe;
	assign drive_out_b_o = drive_reg.b_val;
	assign drive_out_b_oe = drive_reg.b_oe;

	// oscillator kept running for the generator
	// request keeps the oscillator running; the generator itself is still clocked by mclk
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			keep_reg <= 1'b0;
		end
		else
		begin
			keep_reg <= ctl0_reg.module_enable & in_valid
				& ctl0_reg.generator_clock_select;
		end
	end

	assign osc_keep_running = keep_reg;

	chk_sw_force: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_sdc && wdat[7]) |=> (sdc_reg.shutdown_event_status && forced))
		else $error("software shutdown not entered");

	chk_ase_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
		(sdc_reg.shutdown_event_status && !sdc_reg.auto_restart_enable && sd_src)
		|=> sdc_reg.shutdown_event_status)
		else $error("event bit cleared with source active");

	chk_auto_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(sdc_reg.auto_restart_enable && !sd_src && !(wr_sdc && wdat[7])
		&& sdc_reg.shutdown_event_status) |=> !sdc_reg.shutdown_event_status)
		else $error("auto-restart did not clear event bit");

	chk_hold_edge: assert property (@(posedge mclk) disable iff (sys_rst)
		(sd_hold_reg && !rise) |=> sd_hold_reg)
		else $error("override released without rising edge");

	chk_ovr_high: assert property (@(posedge mclk) disable iff (sys_rst)
		(ctl0_reg.module_enable && sd_src && ctl0_reg.out_a_pin_enable
		&& ctl1_reg.out_a_override_level == CDG_OVR_HIGH)
		|=> (drive_out_a_o && drive_out_a_oe))
		else $error("override high not driven on A");

	chk_rise_gap: assert property (@(posedge mclk) disable iff (sys_rst)
		(ctl0_reg.module_enable && rise && !ctl0_reg.generator_clock_select
		&& dbr_reg == 6'h02)
		|=> (!a_on && !b_on) ##1 !a_on)
		else $error("rising dead band too short");

	chk_rise_end: assert property (@(posedge mclk) disable iff (sys_rst)
		(ctl0_reg.module_enable && rise && !ctl0_reg.generator_clock_select
		&& dbr_reg == 6'h02)
		##1 (ctl0_reg.module_enable && in_sel && !ctl0_reg.generator_clock_select
		&& dbr_reg == 6'h02)
		##1 (ctl0_reg.module_enable && in_sel && !ctl0_reg.generator_clock_select
		&& dbr_reg == 6'h02)
		|=> a_on)
		else $error("rising dead band too long");

	chk_fall_gap: assert property (@(posedge mclk) disable iff (sys_rst)
		(ctl0_reg.module_enable && fall && dbf_reg != CDG_CNT_ZERO)
		|=> (!a_on && !b_on))
		else $error("falling dead band overlap");

	chk_disabled: assert property (@(posedge mclk) disable iff (sys_rst)
		!ctl0_reg.module_enable |=> (!drive_out_a_oe && !drive_out_b_oe))
		else $error("pins driven while disabled");

	chk_rsv_low: assert property (@(posedge mclk) disable iff (sys_rst)
		(!in_valid && $stable(ctl1_reg)) |=> !in_prev_reg)
		else $error("reserved input not low");
endmodule
`default_nettype wire

// file: rtl/cdg_pkg.sv
// Constants, field layouts and types of the complementary dead-band generator.
// Assumes a single system clock and an AHB-Lite register port.
`default_nettype none
package cdg_pkg;
	localparam logic [7:0] CDG_OFS_CTL0 = 8'h00;
	localparam logic [7:0] CDG_OFS_CTL1 = 8'h04;
	localparam logic [7:0] CDG_OFS_SDC = 8'h08;
	localparam logic [7:0] CDG_OFS_DBR = 8'h0C;
	localparam logic [7:0] CDG_OFS_DBF = 8'h10;
	localparam logic [7:0] CDG_RST_VAL = 8'h00;
	localparam logic [7:0] CDG_WM_CTL0 = 8'hF9;
	localparam logic [7:0] CDG_WM_CTL1 = 8'hF7;
	localparam logic [7:0] CDG_WM_SDC = 8'hC6;
	localparam logic [7:0] CDG_WM_DB = 8'h3F;
	localparam logic [1:0] CDG_OVR_HIGH = 2'h3;
	localparam logic [1:0] CDG_OVR_LOW = 2'h2;
	localparam logic [1:0] CDG_OVR_HIZ = 2'h1;
	localparam logic [1:0] CDG_OVR_INACT = 2'h0;
	localparam logic [2:0] CDG_IS_CMP = 3'h0;
	localparam logic [2:0] CDG_IS_PWM1 = 3'h2;
	localparam logic [2:0] CDG_IS_PWM2 = 3'h3;
	localparam logic [2:0] CDG_IS_PWM3 = 3'h4;
	localparam logic [1:0] CDG_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CDG_HTRANS_SEQ = 2'h3;
	localparam logic [2:0] CDG_HSIZE_WORD = 3'h2;
	localparam logic [5:0] CDG_CNT_ZERO = 6'h00;
	localparam logic [5:0] CDG_CNT_ONE = 6'h01;
	typedef struct packed {
		logic module_enable;
		logic out_b_pin_enable;
		logic out_a_pin_enable;
		logic out_b_invert;
		logic out_a_invert;
		logic [1:0] unused;
		logic generator_clock_select;
	} cdg_ctl0_t;
	typedef struct packed {
		logic [1:0] out_b_override_level;
		logic [1:0] out_a_override_level;
		logic unused;
		logic [2:0] input_select;
	} cdg_ctl1_t;
	typedef struct packed {
		logic shutdown_event_status;
		logic auto_restart_enable;
		logic [2:0] unused_hi;
		logic comparator_shutdown_enable;
		logic fault_pin_shutdown_enable;
		logic unused_lo;
	} cdg_sdc_t;
	typedef struct packed {
		logic a_val;
		logic a_oe;
		logic b_val;
		logic b_oe;
	} cdg_drive_t;
	typedef enum logic [2:0] {
		CDG_ST_IDLE = 3'b000,
		CDG_ST_RISE = 3'b001,
		CDG_ST_A_ON = 3'b010,
		CDG_ST_FALL = 3'b011,
		CDG_ST_B_ON = 3'b100
	} cdg_state_t;
endpackage
`default_nettype wire

// file: testbench/cdg_far_model.sv
// Far-side model: source lines, fault pin and a free-running 16 MHz oscillator.
// Assumes the bench sets every level through cmd and watches the drivers itself.
`default_nettype none
module cdg_far_model
(
	input wire logic [4:0] cmd,
	output logic pwm_source_one,
	output logic pwm_source_two,
	output logic pwm_source_three,
	output logic comparator_out_async,
	output logic fault_pin_n,
	output var logic osc_16mhz_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pwm_source_one = cmd[0];
	assign pwm_source_two = cmd[1];
	assign pwm_source_three = cmd[2];
	assign comparator_out_async = cmd[3];
	assign fault_pin_n = cmd[4];
	initial
	begin
		osc_16mhz_in = 1'b0;
		forever #31.25 osc_16mhz_in = ~osc_16mhz_in;
	end
endmodule
`default_nettype wire

// file: testbench/tb_cdg_generator.sv
// Testbench of the dead-band generator: bus tasks, scenarios and verdict.
// Assumes the far-side model turns cmd into pin levels; hready loops back.
`default_nettype none
module tb_cdg_generator
	import cdg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] cmd;
	logic [7:0] nr;
	logic rs;
	logic p1, p2, p3, cmp, flt_n, osc, keep, ao, aoe, bo, boe;
	int n_errors, tests_run, seed, g, c;
	logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [7:0] msk [5] = '{8'hF9, 8'hF7, 8'h46, 8'h3F, 8'h3F};
	cdg_far_model cdg_far_model_i (
		.cmd(cmd),
		.pwm_source_one(p1),
		.pwm_source_two(p2),
		.pwm_source_three(p3),
		.comparator_out_async(cmp),
		.fault_pin_n(flt_n),
		.osc_16mhz_in(osc)
	);
	cdg_generator cdg_generator_i (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.pwm_source_one(p1),
		.pwm_source_two(p2),
		.pwm_source_three(p3),
		.comparator_out_async(cmp),
		.fault_pin_n(flt_n),
		.osc_16mhz_in(osc),
		.osc_keep_running(keep),
		.drive_out_a_o(ao),
		.drive_out_a_oe(aoe),
		.drive_out_b_o(bo),
		.drive_out_b_oe(boe)
	);
	task automatic tally_and_finish;
		$display("counts: %0d compares, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	// Address phase, then data phase; each ends at a rising edge with hready high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= CDG_HTRANS_NONSEQ;
		hwrite <= w;
		do
			@(posedge mclk);
		while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge mclk);
		while (hreadyout !== 1'b1);
		rv = hrdata;
		rs = hresp;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h00000000);
		chk({rs | rv[31], rv[30:0]}, {24'h000000, e});
	endtask
	// Cycles from the off-going output falling to the on-going output rising
	task automatic gap(input logic r, output int n);
		int k;
		k = 0;
		n = 0;
		while ((r ? bo : ao) !== 1'b0 && k < 300)
		begin
			@(negedge mclk);
			k++;
		end
		while ((r ? ao : bo) !== 1'b1 && n < 300)
		begin
			@(negedge mclk);
			n++;
		end
	endtask
	// Expected {level, enable} of a pin in shutdown
	function automatic logic [1:0] ovr(input logic [1:0] k, input logic inv);
		return (k == CDG_OVR_HIZ) ? 2'b00 : {(k == CDG_OVR_INACT) ? inv : k[0], 1'b1};
	endfunction
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		#500000;
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = CDG_HSIZE_WORD;
		hwdata = 32'h00000000;
		cmd = 5'h10;
		seed = 32'hCDD0;
		n_errors = 0;
		tests_run = 0;
		cyc(16);
		sys_rst <= 1'b0;
		cyc(1);
		for (g = 0; g < 5; g++)
		begin
			rd(ofs[g], 8'h00);
			wr(ofs[g], 8'hFF);
			rd(ofs[g], msk[g]);
			wr(ofs[g], 8'h00);
			rd(ofs[g], 8'h00);
		end
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h00);
		fin("registers");
		wr(CDG_OFS_CTL1, 8'hE2);
		wr(CDG_OFS_SDC, 8'h80);
		wr(CDG_OFS_CTL0, 8'hE0);
		cyc(4);
		chk({ao, aoe, bo, boe}, 4'b0111);
		wr(CDG_OFS_SDC, 8'h00);
		cyc(10);
		chk({ao, bo}, 2'b01);
		for (g = 0; g < 4; g++)
		begin
			nr = (g == 0) ? 8'h00 : (g == 1) ? 8'h3F : (g == 2) ? 8'h02
				: 8'($random(seed)) & 8'h3F;
			wr(CDG_OFS_DBR, nr);
			wr(CDG_OFS_DBF, 8'h3F - nr);
			cmd[0] <= 1'b1;
			gap(1'b1, c);
			chk(c, nr);
			cyc(80);
			cmd[0] <= 1'b0;
			gap(1'b0, c);
			chk(c, 8'h3F - nr);
			cyc(80);
		end
		fin("dead band");
		wr(CDG_OFS_CTL0, 8'hE8);
		for (g = 0; g < 4; g++)
		begin
			wr(CDG_OFS_CTL1, {2'(g), 2'(3 - g), 4'h2});
			wr(CDG_OFS_SDC, 8'h80);
			cyc(4);
			chk({bo & boe, boe, ao & aoe, aoe}, {ovr(2'(g), 1'b0), ovr(2'(3 - g), 1'b1)});
		end
		wr(CDG_OFS_CTL0, 8'h40);
		cyc(4);
		chk({aoe, boe}, 2'b00);
		wr(CDG_OFS_CTL0, 8'hC0);
		cyc(4);
		chk({aoe, boe}, 2'b01);
		fin("overrides");
		wr(CDG_OFS_CTL0, 8'hE0);
		wr(CDG_OFS_CTL1, 8'hB2);
		wr(CDG_OFS_SDC, 8'h00);
		cmd[0] <= 1'b1;
		cyc(80);
		cmd[0] <= 1'b0;
		cyc(80);
		wr(CDG_OFS_SDC, 8'h02);
		cmd[4] <= 1'b0;
		c = 0;
		while ({ao, bo} !== 2'b10 && c < 20)
		begin
			@(negedge mclk);
			c++;
		end
		chk(c <= 6, 1);
		rd(CDG_OFS_SDC, 8'h82);
		wr(CDG_OFS_SDC, 8'h02);
		rd(CDG_OFS_SDC, 8'h82);
		cmd[4] <= 1'b1;
		cyc(6);
		rd(CDG_OFS_SDC, 8'h82);
		wr(CDG_OFS_SDC, 8'h02);
		rd(CDG_OFS_SDC, 8'h02);
		chk({ao, bo}, 2'b10);
		wr(CDG_OFS_SDC, 8'h00);
		cmd[4] <= 1'b0;
		cyc(6);
		rd(CDG_OFS_SDC, 8'h00);
		cmd[4] <= 1'b1;
		fin("fault pin");
		wr(CDG_OFS_SDC, 8'h44);
		cmd[3] <= 1'b1;
		cyc(6);
		rd(CDG_OFS_SDC, 8'hC4);
		cmd[3] <= 1'b0;
		cyc(6);
		rd(CDG_OFS_SDC, 8'h44);
		chk({ao, bo}, 2'b10);
		cmd[0] <= 1'b1;
		cyc(80);
		cmd[0] <= 1'b0;
		cyc(80);
		chk({ao, bo}, 2'b01);
		wr(CDG_OFS_CTL0, 8'hF8);
		cyc(3);
		chk({ao, bo}, 2'b10);
		wr(CDG_OFS_SDC, 8'hC0);
		cyc(2);
		rd(CDG_OFS_SDC, 8'h40);
		fin("auto restart");
		wr(CDG_OFS_DBR, 8'h00);
		wr(CDG_OFS_DBF, 8'h00);
		wr(CDG_OFS_CTL0, 8'hE1);
		for (g = 0; g < 8; g++)
		begin
			wr(CDG_OFS_CTL1, 8'(g));
			cmd[3:0] <= 4'hF;
			cyc(10);
			c = (g == 0 || g == 2 || g == 3 || g == 4);
			chk(keep, c);
			chk(ao, c);
			cmd[3:0] <= 4'h0;
			cyc(10);
		end
		wr(CDG_OFS_CTL1, 8'h02);
		wr(CDG_OFS_DBR, 8'h08);
		cmd[0] <= 1'b1;
		gap(1'b1, c);
		chk(c >= 21 && c <= 29, 1);
		fin("input select");
		tally_and_finish();
	end
endmodule
`default_nettype wire
